// >>> hdl/bank_fsm.sv
// one bank: state register with its own tRCD, tWR and tRP timer
module bank_fsm (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // accepted command strobes for this bank
  input wire logic do_act,
  input wire logic do_rd,
  input wire logic do_wr,
  input wire logic do_pre,
  input wire logic auto_pre,
  input wire logic burst_end,
  // bank state
  output sdram_pkg::bank_state_e state
);
  localparam int RCD_D = int'(sdram_pkg::RCD_CYC) + 1;
  localparam int RP_D = int'(sdram_pkg::RP_CYC) + 1;
  localparam int WRP_D = int'(sdram_pkg::WR_CYC) + int'(sdram_pkg::RP_CYC) + 1;

  logic [sdram_pkg::CNT_W-1:0] cnt;
  logic [1:0] phase;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= sdram_pkg::B_IDLE;
      cnt <= 4'h0;
      phase <= sdram_pkg::AP_BURST;
    end else if (clk_en) begin
      unique case (state)
        // a precharge here is simply ignored
        sdram_pkg::B_IDLE: begin
          if (do_act) begin
            state <= sdram_pkg::B_ACTIVATING;
            cnt <= sdram_pkg::RCD_LOAD;
          end
        end
        sdram_pkg::B_ACTIVATING: begin
          if (cnt == 4'h0) begin
            state <= sdram_pkg::B_ACTIVE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        sdram_pkg::B_ACTIVE, sdram_pkg::B_READ, sdram_pkg::B_WRITE: begin
          if (do_pre) begin
            state <= sdram_pkg::B_PRECHARGING;
            cnt <= sdram_pkg::RP_LOAD;
          end else if (do_rd) begin
            state <= auto_pre ? sdram_pkg::B_READ_AP : sdram_pkg::B_READ;
            phase <= sdram_pkg::AP_BURST;
          end else if (do_wr) begin
            state <= auto_pre ? sdram_pkg::B_WRITE_AP : sdram_pkg::B_WRITE;
            phase <= sdram_pkg::AP_BURST;
          end else if (burst_end) begin
            state <= sdram_pkg::B_ACTIVE;
          end
        end
        sdram_pkg::B_READ_AP, sdram_pkg::B_WRITE_AP: begin
          if (phase == sdram_pkg::AP_BURST) begin
            // burst over or cut by another bank: read precharge starts now, write waits tWR first
            if (burst_end) begin
              if (state == sdram_pkg::B_WRITE_AP) begin
                phase <= sdram_pkg::AP_RECOVER;
                cnt <= sdram_pkg::WR_LOAD;
              end else begin
                phase <= sdram_pkg::AP_PRECHARGE;
                cnt <= sdram_pkg::RP_LOAD;
              end
            end
          end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
          end else if (phase == sdram_pkg::AP_RECOVER) begin
            phase <= sdram_pkg::AP_PRECHARGE;
            cnt <= sdram_pkg::RP_LOAD;
          end else begin
            state <= sdram_pkg::B_IDLE;
            phase <= sdram_pkg::AP_BURST;
          end
        end
        sdram_pkg::B_PRECHARGING: begin
          if (cnt == 4'h0) begin
            state <= sdram_pkg::B_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          state <= sdram_pkg::B_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!rst_b);

  chk_idle_pre_nop: assert property ((state == sdram_pkg::B_IDLE) && do_pre && !do_act
    |=> state == sdram_pkg::B_IDLE) else $error("precharge moved an idle bank");
  chk_rdap_to_idle: assert property ((state == sdram_pkg::B_READ_AP) &&
    (phase == sdram_pkg::AP_BURST) && burst_end
    |-> ##RP_D state == sdram_pkg::B_IDLE) else $error("read auto precharge not idle after tRP");
  chk_wrap_to_idle: assert property ((state == sdram_pkg::B_WRITE_AP) &&
    (phase == sdram_pkg::AP_BURST) && burst_end
    |-> ##WRP_D state == sdram_pkg::B_IDLE) else $error("write auto precharge not idle after tWR plus tRP");
  chk_act_timing: assert property ((state == sdram_pkg::B_IDLE) && do_act
    |-> ##RCD_D state == sdram_pkg::B_ACTIVE) else $error("row not active after tRCD");
endmodule // bank_fsm

// >>> hdl/sdram_bank_tracker.sv
// bank command legality, per-bank sequencing and data bus ownership
module sdram_bank_tracker (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // command bus
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [1:0] ba,
  input wire logic a10,
  // state
  output sdram_pkg::bank_state_e [3:0] bank_state,
  output sdram_pkg::dev_state_e dev_state,
  output logic cmd_illegal,
  // data bus ownership
  output logic rd_drive,
  output logic [1:0] rd_bank,
  output logic wr_capture,
  output logic [1:0] wr_bank
);
  localparam int CL = sdram_pkg::CAS_LAT;
  localparam int RC_D = int'(sdram_pkg::RC_CYC) + 1;
  localparam int MRD_D = int'(sdram_pkg::MRD_CYC) + 1;
  localparam int RP_D = int'(sdram_pkg::RP_CYC) + 1;

  logic [3:0] cmd;
  logic busy;
  sdram_pkg::bank_state_e tgt;
  logic tgt_open;
  logic [3:0] idle_v;
  logic [3:0] prechg_v;
  logic [3:0] end_v;
  logic ok_act;
  logic ok_rd;
  logic ok_wr;
  logic ok_pre1;
  logic ok_prea;
  logic ok_ref;
  logic ok_lmr;
  logic ok_bst;
  logic illegal_now;
  logic burst_on;
  logic burst_is_rd;
  logic [1:0] burst_bank;
  logic [1:0] burst_cnt;
  logic cut;
  logic cont;
  logic rd_issue;
  logic wr_issue;
  logic [1:0] issue_bank;
  logic [CL-1:0] rd_pipe_v;
  logic [CL-1:0][1:0] rd_pipe_b;
  logic [sdram_pkg::CNT_W-1:0] g_cnt;

  assign cmd = {cs_b, ras_b, cas_b, we_b};

  // bank commands look only at the addressed bank's own state; refresh, mode load and precharge all need every bank
  always_comb begin
    busy = dev_state != sdram_pkg::G_NORMAL;
    tgt = bank_state[ba];
    tgt_open = tgt inside {sdram_pkg::B_ACTIVE, sdram_pkg::B_READ, sdram_pkg::B_WRITE};
    ok_act = !busy && (cmd == sdram_pkg::CMD_ACT) && (tgt == sdram_pkg::B_IDLE);
    ok_rd = !busy && (cmd == sdram_pkg::CMD_RD) && tgt_open;
    ok_wr = !busy && (cmd == sdram_pkg::CMD_WR) && tgt_open;
    ok_pre1 = !busy && (cmd == sdram_pkg::CMD_PRE) && !a10 && (tgt_open || (tgt == sdram_pkg::B_IDLE));
    ok_prea = !busy && (cmd == sdram_pkg::CMD_PRE) && a10 && (&prechg_v);
    ok_ref = !busy && (cmd == sdram_pkg::CMD_REF) && (&idle_v);
    ok_lmr = !busy && (cmd == sdram_pkg::CMD_LMR) && (&idle_v);
    // the bank address is ignored: the latest burst is the one hit
    ok_bst = !busy && (cmd == sdram_pkg::CMD_BST) && burst_on &&
      (bank_state[burst_bank] inside {sdram_pkg::B_READ, sdram_pkg::B_WRITE});
    // anything else but nop or inhibit is refused, busy device included
    illegal_now = !cs_b && (cmd != sdram_pkg::CMD_NOP) &&
      !(ok_act || ok_rd || ok_wr || ok_pre1 || ok_prea || ok_ref || ok_lmr || ok_bst);
  end

  // a precharge to another bank is not a cut
  always_comb begin
    cut = ok_rd || ok_wr || ok_bst || ok_prea || (ok_pre1 && (ba == burst_bank));
    cont = burst_on && (burst_cnt != 2'h0) && !cut;
    rd_issue = ok_rd || (cont && burst_is_rd);
    wr_issue = ok_wr || (cont && !burst_is_rd);
    issue_bank = (ok_rd || ok_wr) ? ba : burst_bank;
  end

  generate
    for (genvar i = 0; i < sdram_pkg::NUM_BANKS; i++) begin : g_bank
      localparam logic [1:0] IDX = 2'(i);
      assign idle_v[i] = bank_state[i] == sdram_pkg::B_IDLE;
      assign prechg_v[i] = bank_state[i] inside {sdram_pkg::B_IDLE, sdram_pkg::B_ACTIVE,
        sdram_pkg::B_READ, sdram_pkg::B_WRITE};
      // the running burst ends naturally, by terminate or by another bank's burst
      assign end_v[i] = burst_on && (burst_bank == IDX) &&
        (ok_bst || ((ok_rd || ok_wr) && (ba != IDX)) || (burst_cnt == 2'h0));
      bank_fsm u_bank (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .do_act(ok_act && (ba == IDX)),
        .do_rd(ok_rd && (ba == IDX)),
        .do_wr(ok_wr && (ba == IDX)),
        .do_pre((ok_pre1 && (ba == IDX)) || ok_prea),
        .auto_pre(a10),
        .burst_end(end_v[i]),
        .state(bank_state[i])
      );
    end
  endgenerate

  // burst tracker: only the most recent read or write is ever live
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      burst_on <= 1'b0;
      burst_is_rd <= 1'b0;
      burst_bank <= 2'h0;
      burst_cnt <= 2'h0;
    end else if (clk_en) begin
      if (ok_rd || ok_wr) begin
        burst_on <= 1'b1;
        burst_is_rd <= ok_rd;
        burst_bank <= ba;
        burst_cnt <= sdram_pkg::BL_LOAD;
      end else if (cut || (burst_cnt == 2'h0)) begin
        burst_on <= 1'b0;
      end else begin
        burst_cnt <= burst_cnt - 2'h1;
      end
    end
  end

  // read data path; a write flushes words in flight, the controller masks them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_pipe_v <= '0;
      rd_pipe_b <= '0;
    end else if (clk_en) begin
      if (ok_wr) begin
        rd_pipe_v <= '0;
      end else begin
        rd_pipe_v <= {rd_pipe_v[CL-2:0], rd_issue};
      end
      rd_pipe_b <= {rd_pipe_b[CL-2:0], issue_bank};
    end
  end

  assign rd_drive = rd_pipe_v[CL-1];
  assign rd_bank = rd_pipe_b[CL-1];

  // write capture stops at the edge that registers the next read or write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_capture <= 1'b0;
      wr_bank <= 2'h0;
    end else if (clk_en) begin
      wr_capture <= wr_issue;
      wr_bank <= issue_bank;
    end
  end

  // shared device timer for refresh, mode access and precharge all
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dev_state <= sdram_pkg::G_NORMAL;
      g_cnt <= 4'h0;
    end else if (clk_en) begin
      unique case (dev_state)
        sdram_pkg::G_NORMAL: begin
          if (ok_ref) begin
            dev_state <= sdram_pkg::G_REFRESH;
            g_cnt <= sdram_pkg::RC_LOAD;
          end else if (ok_lmr) begin
            dev_state <= sdram_pkg::G_MODE;
            g_cnt <= sdram_pkg::MRD_LOAD;
          end else if (ok_prea) begin
            dev_state <= sdram_pkg::G_PREALL;
            g_cnt <= sdram_pkg::RP_LOAD;
          end
        end
        sdram_pkg::G_REFRESH, sdram_pkg::G_MODE, sdram_pkg::G_PREALL: begin
          if (g_cnt == 4'h0) begin
            dev_state <= sdram_pkg::G_NORMAL;
          end else begin
            g_cnt <= g_cnt - 4'h1;
          end
        end
        default: begin
          dev_state <= sdram_pkg::G_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_illegal <= 1'b0;
    end else if (clk_en) begin
      cmd_illegal <= illegal_now;
    end
  end

  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!rst_b);

  chk_busy_refuses_cmd: assert property (busy && !cs_b && (cmd != sdram_pkg::CMD_NOP)
    |=> cmd_illegal) else $error("command taken while device busy");
  chk_refresh_length: assert property (ok_ref
    |-> ##RC_D (dev_state == sdram_pkg::G_NORMAL) && (&idle_v)) else $error("refresh not done after tRC");
  chk_mode_length: assert property (ok_lmr
    |=> (dev_state == sdram_pkg::G_MODE) ##(MRD_D - 1) (dev_state == sdram_pkg::G_NORMAL))
    else $error("mode access not done after tMRD");
  chk_preall_idle: assert property (ok_prea
    |-> ##RP_D (dev_state == sdram_pkg::G_NORMAL) && (&idle_v)) else $error("banks not idle after precharge all");
  chk_read_latency: assert property (ok_rd ##1 !ok_wr ##1 !ok_wr
    |=> rd_drive && (rd_bank == $past(ba, 3))) else $error("read data not on bus after CAS latency");
  chk_write_cuts_read: assert property (ok_wr |=> !rd_drive && wr_capture)
    else $error("read data still driven after write");
  chk_bst_ends_burst: assert property (ok_bst |=> !burst_on) else $error("burst terminate ignored");
  chk_illegal_flag: assert property (illegal_now |=> cmd_illegal) else $error("illegal command not flagged");

  cov_refresh: cover property (ok_ref);
  cov_read_interrupt: cover property (burst_on && burst_is_rd && ok_rd && (ba != burst_bank));
  cov_wrap_interrupt: cover property (burst_on && (ok_rd || ok_wr) && (ba != burst_bank) &&
    (bank_state[burst_bank] == sdram_pkg::B_WRITE_AP));
  cov_precharge_all: cover property (ok_prea);
endmodule // sdram_bank_tracker

// >>> hdl/sdram_pkg.sv
// package: command codes, timings and state encodings of the bank tracker
// Overview of operation
// - read with auto precharge idles after tRP
// - write with auto precharge idles after tWR plus tRP
// - auto refresh holds device busy for tRC
// - load mode register holds device busy tMRD
// - precharge all busy tRP, then banks idle
// - burst terminate hits latest burst, any bank
// - precharge to idle bank is a no-op
// - decode commands from cs, ras, cas, we
// - cross-bank commands judged by target bank only
// - interrupted auto-precharge burst starts own precharge
// - precharge elsewhere leaves running burst intact
// - interrupting read takes bus CAS latency later
// - write cuts plain read at registration
// - write interrupting auto-precharge read starts its precharge
// - read ends write burst at registration
// - write ends write burst at registration
// - interrupted auto-precharge read precharges at interrupt
// - interrupted auto-precharge write waits tWR first
// - address bit 10 selects auto precharge
package sdram_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_RP_NS = 20;
  localparam int T_RCD_NS = 20;
  localparam int T_WR_NS = 15;
  localparam int T_RC_NS = 70;
  localparam int T_MRD_CLK = 2;
  localparam int NUM_BANKS = 4;
  localparam int CAS_LAT = 3;
  localparam int BURST_LEN = 4;
  localparam int CNT_W = 4;

  localparam logic [3:0] RP_CYC = 4'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RCD_CYC = 4'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WR_CYC = 4'((T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RC_CYC = 4'((T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] MRD_CYC = 4'(T_MRD_CLK);
  localparam logic [3:0] RP_LOAD = RP_CYC - 4'h1;
  localparam logic [3:0] RCD_LOAD = RCD_CYC - 4'h1;
  localparam logic [3:0] WR_LOAD = WR_CYC - 4'h1;
  localparam logic [3:0] RC_LOAD = RC_CYC - 4'h1;
  localparam logic [3:0] MRD_LOAD = MRD_CYC - 4'h1;
  localparam logic [1:0] BL_LOAD = 2'(BURST_LEN - 1);

  // {cs_b, ras_b, cas_b, we_b}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  localparam logic [1:0] AP_BURST = 2'h0;
  localparam logic [1:0] AP_RECOVER = 2'h1;
  localparam logic [1:0] AP_PRECHARGE = 2'h2;

  typedef enum logic [7:0] {
    B_IDLE = 8'h01,
    B_ACTIVATING = 8'h02,
    B_ACTIVE = 8'h04,
    B_READ = 8'h08,
    B_WRITE = 8'h10,
    B_READ_AP = 8'h20,
    B_WRITE_AP = 8'h40,
    B_PRECHARGING = 8'h80
  } bank_state_e;

  typedef enum logic [3:0] {
    G_NORMAL = 4'h1,
    G_REFRESH = 4'h2,
    G_MODE = 4'h4,
    G_PREALL = 4'h8
  } dev_state_e;
endpackage

// >>> verification/sdram_bank_command_rules_tb.sv
// testbench: bank tracker driven by the controller model
module sdram_bank_command_rules_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys;
  logic rst_b;
  logic clk_en;
  logic cs_b;
  logic ras_b;
  logic cas_b;
  logic we_b;
  logic a10;
  logic [1:0] ba;
  logic [1:0] rd_bank;
  logic [1:0] wr_bank;
  sdram_pkg::bank_state_e [3:0] bank_state;
  sdram_pkg::dev_state_e dev_state;
  logic cmd_illegal;
  logic rd_drive;
  logic wr_capture;
  int error_cnt;
  int compares;
  int rd_cnt[4];
  int wr_cnt[4];

  sdram_ctl_model ctl (.clk_sys(clk_sys), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .a10(a10));

  sdram_bank_tracker uut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .cs_b(cs_b), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .ba(ba), .a10(a10), .bank_state(bank_state), .dev_state(dev_state),
    .cmd_illegal(cmd_illegal), .rd_drive(rd_drive), .rd_bank(rd_bank), .wr_capture(wr_capture), .wr_bank(wr_bank));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // counted on the rising edge so the falling-edge tests never race the tally
  always @(posedge clk_sys) begin
    if (rd_drive === 1'b1) rd_cnt[rd_bank]++;
    if (wr_capture === 1'b1) wr_cnt[wr_bank]++;
  end

  task automatic cmp_st(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_n(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic clr();
    foreach (rd_cnt[i]) begin
      rd_cnt[i] = 0;
      wr_cnt[i] = 0;
    end
  endtask

  // bounded wait for a bank to settle in a state
  task automatic wait_bank(input int b, input logic [7:0] st);
    int n;
    n = 0;
    while (bank_state[b] !== st && n < 12) begin
      n++;
      @(negedge clk_sys);
    end
    cmp_st(bank_state[b], st);
  endtask

  // counts the remaining falling edges spent in a device-wide state
  task automatic dev_hold(input logic [3:0] s, input int exp);
    int n;
    n = 0;
    while (dev_state === s && n < 12) begin
      n++;
      @(negedge clk_sys);
    end
    cmp_n(n, exp);
    cmp_st(dev_state, sdram_pkg::G_NORMAL);
  endtask

  task automatic act_wait(input logic [1:0] b);
    ctl.issue(sdram_pkg::CMD_ACT, b, 1'b0);
    ctl.idle(0);
    wait_bank(b, sdram_pkg::B_ACTIVE);
  endtask

  task automatic t_reset();
    foreach (bank_state[i]) cmp_st(bank_state[i], sdram_pkg::B_IDLE);
    cmp_st(dev_state, sdram_pkg::G_NORMAL);
    cmp_n({cmd_illegal, rd_drive, wr_capture}, 0);
    $display("test reset done");
  endtask

  task automatic t_read();
    clr();
    act_wait(2'h0);
    ctl.issue(sdram_pkg::CMD_RD, 2'h0, 1'b0);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_READ);
    wait_bank(0, sdram_pkg::B_ACTIVE);
    ctl.idle(4);
    cmp_n(rd_cnt[0], sdram_pkg::BURST_LEN);
    $display("test read done");
  endtask

  task automatic t_auto_pre();
    clr();
    act_wait(2'h1);
    ctl.issue(sdram_pkg::CMD_WR, 2'h1, 1'b1);
    ctl.idle(0);
    cmp_st(bank_state[1], sdram_pkg::B_WRITE_AP);
    wait_bank(1, sdram_pkg::B_IDLE);
    cmp_n(wr_cnt[1], sdram_pkg::BURST_LEN);
    ctl.issue(sdram_pkg::CMD_RD, 2'h0, 1'b1);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_READ_AP);
    wait_bank(0, sdram_pkg::B_IDLE);
    ctl.idle(3);
    cmp_n(rd_cnt[0], sdram_pkg::BURST_LEN);
    $display("test auto precharge done");
  endtask

  task automatic t_device_busy();
    ctl.issue(sdram_pkg::CMD_REF, 2'h0, 1'b0);
    ctl.issue(sdram_pkg::CMD_ACT, 2'h2, 1'b0);
    cmp_n(cmd_illegal, 1);
    cmp_st(bank_state[2], sdram_pkg::B_IDLE);
    ctl.idle(0);
    dev_hold(sdram_pkg::G_REFRESH, int'(sdram_pkg::RC_CYC) - 1);
    foreach (bank_state[i]) cmp_st(bank_state[i], sdram_pkg::B_IDLE);
    ctl.issue(sdram_pkg::CMD_LMR, 2'h0, 1'b0);
    ctl.idle(0);
    dev_hold(sdram_pkg::G_MODE, int'(sdram_pkg::MRD_CYC));
    $display("test device busy done");
  endtask

  task automatic t_illegal();
    ctl.issue(sdram_pkg::CMD_RD, 2'h2, 1'b0);
    ctl.idle(0);
    cmp_n(cmd_illegal, 1);
    cmp_st(bank_state[2], sdram_pkg::B_IDLE);
    ctl.issue(sdram_pkg::CMD_PRE, 2'h3, 1'b0);
    ctl.idle(0);
    cmp_n(cmd_illegal, 0);
    cmp_st(bank_state[3], sdram_pkg::B_IDLE);
    act_wait(2'h0);
    ctl.issue(sdram_pkg::CMD_REF, 2'h0, 1'b0);
    ctl.idle(0);
    cmp_n(cmd_illegal, 1);
    cmp_st(dev_state, sdram_pkg::G_NORMAL);
    $display("test illegal done");
  endtask

  task automatic t_cross_bank();
    clr();
    ctl.issue(sdram_pkg::CMD_RD, 2'h0, 1'b0);
    ctl.issue(sdram_pkg::CMD_BST, 2'h3, 1'b0);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_ACTIVE);
    ctl.idle(6);
    cmp_n(rd_cnt[0], 1);
    clr();
    act_wait(2'h2);
    ctl.issue(sdram_pkg::CMD_RD, 2'h0, 1'b0);
    ctl.issue(sdram_pkg::CMD_PRE, 2'h2, 1'b0);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_READ);
    wait_bank(2, sdram_pkg::B_IDLE);
    wait_bank(0, sdram_pkg::B_ACTIVE);
    ctl.idle(4);
    cmp_n(rd_cnt[0], sdram_pkg::BURST_LEN);
    $display("test cross bank done");
  endtask

  task automatic t_concurrent();
    clr();
    act_wait(2'h1);
    ctl.issue(sdram_pkg::CMD_RD, 2'h0, 1'b1);
    ctl.issue(sdram_pkg::CMD_RD, 2'h1, 1'b0);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_READ_AP);
    cmp_st(bank_state[1], sdram_pkg::B_READ);
    wait_bank(0, sdram_pkg::B_IDLE);
    wait_bank(1, sdram_pkg::B_ACTIVE);
    ctl.idle(4);
    cmp_n(rd_cnt[0], 1);
    cmp_n(rd_cnt[1], sdram_pkg::BURST_LEN);
    clr();
    act_wait(2'h0);
    ctl.issue(sdram_pkg::CMD_WR, 2'h0, 1'b1);
    ctl.issue(sdram_pkg::CMD_WR, 2'h1, 1'b0);
    ctl.idle(0);
    cmp_st(bank_state[0], sdram_pkg::B_WRITE_AP);
    cmp_st(bank_state[1], sdram_pkg::B_WRITE);
    ctl.idle(1);
    cmp_st(bank_state[0], sdram_pkg::B_WRITE_AP);
    wait_bank(0, sdram_pkg::B_IDLE);
    wait_bank(1, sdram_pkg::B_ACTIVE);
    ctl.idle(2);
    cmp_n(wr_cnt[0], 1);
    cmp_n(wr_cnt[1], sdram_pkg::BURST_LEN);
    $display("test concurrent done");
  endtask

  // a command under a low enable must be lost; a mid-run reset idles an open bank
  task automatic t_freeze_reset();
    clk_en = 1'b0;
    ctl.issue(sdram_pkg::CMD_ACT, 2'h2, 1'b0);
    ctl.idle(1);
    cmp_st(bank_state[2], sdram_pkg::B_IDLE);
    cmp_n(cmd_illegal, 0);
    clk_en = 1'b1;
    act_wait(2'h2);
    rst_b = 1'b0;
    @(negedge clk_sys);
    cmp_st(bank_state[2], sdram_pkg::B_IDLE);
    rst_b = 1'b1;
    @(negedge clk_sys);
    cmp_st(dev_state, sdram_pkg::G_NORMAL);
    act_wait(2'h3);
    $display("test freeze and reset done");
  endtask

  task automatic t_pre_all();
    ctl.issue(sdram_pkg::CMD_PRE, 2'h0, 1'b1);
    ctl.idle(0);
    dev_hold(sdram_pkg::G_PREALL, int'(sdram_pkg::RP_CYC));
    foreach (bank_state[i]) cmp_st(bank_state[i], sdram_pkg::B_IDLE);
    $display("test precharge all done");
  endtask

  task automatic summarize();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    error_cnt = 0;
    compares = 0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    clr();
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_read();
    t_auto_pre();
    t_device_busy();
    t_illegal();
    t_cross_bank();
    t_concurrent();
    t_freeze_reset();
    t_pre_all();
    summarize();
  end

  // the whole sequence needs about a hundred cycles; reaching 3000 means a hang
  initial begin
    #(25 * 3000);
    error_cnt++;
    summarize();
  end
endmodule // sdram_bank_command_rules_tb

// >>> verification/sdram_ctl_model.sv
// controller model: drives commands onto the bank tracker's command bus
module sdram_ctl_model (
  // clock
  input wire logic clk_sys,
  // command bus
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [1:0] ba,
  output logic a10
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {cs_b, ras_b, cas_b, we_b} = sdram_pkg::CMD_NOP;
    ba = 2'h0;
    a10 = 1'b0;
  end

  // caller stands at a falling edge; the code is held across one rising edge
  task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic ap);
    {cs_b, ras_b, cas_b, we_b} = code;
    ba = b;
    a10 = ap;
    @(negedge clk_sys);
  endtask

  // deselect; the other lines flip so a stale code is never mistaken for a live one
  task automatic idle(input int n);
    cs_b = 1'b1;
    ras_b = ~ras_b;
    cas_b = ~cas_b;
    we_b = ~we_b;
    ba = ~ba;
    a10 = ~a10;
    repeat (n) @(negedge clk_sys);
  endtask
endmodule // sdram_ctl_model
